// >>> src/port_media_np_defs.vh
// Overview of operation
// - media select bit, read/write, resets to 1: 1 copper, 0 fiber
// - fiber mode bypasses line encoder/decoder and scrambler/descrambler in the data path
// - bit 15 reports more-pages flag: 1 more follow, 0 last; resets 0
// - bit 13 reports page type: 1 message page, 0 unformatted; resets 1
// - bit 12 reports comply-ack flag: 1 able, 0 unable; resets 0
// - each next page toggle is inverse of previously exchanged codeword toggle
// - first next page toggle is inverse of base codeword bit 11
// - toggle encodes 1 after previous 0, and 0 after previous 1
// - bits 10..0 carry the eleven-bit code, reset value 0x001
`ifndef PORT_MEDIA_NP_DEFS_VH
`define PORT_MEDIA_NP_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFF_PORT_MEDIA_CONFIG    12'h0d8
`define OFF_AUTONEG_NP_TRANSMIT  12'h0dc

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MEDIA_SEL_BIT            6
`define MORE_PAGES_BIT           15
`define PAGE_TYPE_BIT            13
`define COMPLY_ACK_BIT           12
`define TOGGLE_BIT               11
`define BASE_TOGGLE_BIT          11

// ------------------------------------------------------------
// reset values and rw write mask
// ------------------------------------------------------------
`define RST_MEDIA_CONFIG         16'h00fe
`define MEDIA_CONFIG_RW_MASK     16'h00cf
`define RST_MORE_PAGES           1'b0
`define RST_PAGE_TYPE            1'b1
`define RST_COMPLY_ACK           1'b0
`define RST_NP_CODE              11'h001

`endif

// >>> src/np_toggle_track.v
`timescale 1ns/1ps
`default_nettype none
module np_toggle_track (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // page events
  input  wire        base_sent,
  input  wire        base_toggle,
  input  wire        page_sent,
  // toggle to transmit
  output reg         toggle_q
);

// ------------------------------------------------------------
// toggle tracking
// ------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      toggle_q <= 1'b0;
    end else if (base_sent) begin
      toggle_q <= ~base_toggle;
    end else if (page_sent) begin
      toggle_q <= ~toggle_q;
    end
  end

endmodule
`default_nettype wire

// >>> src/port_media_next_page_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "port_media_np_defs.vh"
module port_media_next_page_regs (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // next page content from the negotiation engine
  input  wire        more_pages_flag,
  input  wire        page_type_flag,
  input  wire        comply_ack_flag,
  input  wire [10:0] np_code,
  input  wire        np_load,
  // page exchange events
  input  wire        base_sent,
  input  wire        base_toggle,
  input  wire        page_sent,
  // physical layer path control
  output wire        copper_mode,
  output wire        line_coder_bypass,
  output wire        scrambler_bypass,
  // codeword to transmit
  output wire [15:0] np_codeword
);

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
  reg  [15:0] media_cfg_q;
  reg  [15:0] media_cfg_d;
  reg         more_pages_q;
  reg         page_type_q;
  reg         comply_ack_q;
  reg  [10:0] np_code_q;
  wire        toggle_q;
  wire        access;
  wire        hit_cfg;
  wire        hit_np;
  wire [15:0] np_word;

  assign access  = psel & penable;
  // word decode: the two low address bits are ignored
  assign hit_cfg = ((paddr & 12'hffc) == `OFF_PORT_MEDIA_CONFIG);
  assign hit_np  = ((paddr & 12'hffc) == `OFF_AUTONEG_NP_TRANSMIT);
  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~(hit_cfg | hit_np);

// ------------------------------------------------------------
// media config write, only rw bits take data
// ------------------------------------------------------------
  always @* begin
    media_cfg_d = media_cfg_q;
    if (access && pwrite && hit_cfg) begin
      if (pstrb[0]) begin
        media_cfg_d = ({8'h00, pwdata[7:0]} & `MEDIA_CONFIG_RW_MASK)
                    | (media_cfg_q & ~`MEDIA_CONFIG_RW_MASK);
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      media_cfg_q <= `RST_MEDIA_CONFIG;
    end else begin
      media_cfg_q <= media_cfg_d;
    end
  end

  assign copper_mode       = media_cfg_q[`MEDIA_SEL_BIT];
  // fiber path skips three-level coding and scrambling
  assign line_coder_bypass = ~media_cfg_q[`MEDIA_SEL_BIT];
  assign scrambler_bypass  = ~media_cfg_q[`MEDIA_SEL_BIT];
  // dsp bit 13 lives elsewhere; software must clear it for fiber

// ------------------------------------------------------------
// next page transmit content, read-only to software
// ------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      more_pages_q <= `RST_MORE_PAGES;
      page_type_q  <= `RST_PAGE_TYPE;
      comply_ack_q <= `RST_COMPLY_ACK;
      np_code_q    <= `RST_NP_CODE;
    end else if (np_load) begin
      more_pages_q <= more_pages_flag;
      page_type_q  <= page_type_flag;
      comply_ack_q <= comply_ack_flag;
      np_code_q    <= np_code;
    end
  end

  np_toggle_track u_toggle (
    .clock       (clock),
    .rst_n       (rst_n),
    .base_sent   (base_sent),
    .base_toggle (base_toggle),
    .page_sent   (page_sent),
    .toggle_q    (toggle_q)
  );

  assign np_word = {more_pages_q, 1'b0, page_type_q, comply_ack_q,
                    toggle_q, np_code_q};
  assign np_codeword = np_word;

// ------------------------------------------------------------
// read data
// ------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_cfg) begin
        prdata <= {16'h0000, media_cfg_q};
      end else if (hit_np) begin
        prdata <= {16'h0000, np_word};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/pm_mon_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pm_mon (
  input wire logic clock, rst_n, psel, penable, pwrite, np_load, base_sent, page_sent,
  input wire logic base_toggle, more_pages_flag, page_type_flag, comply_ack_flag,
  input wire logic copper_mode, line_coder_bypass, scrambler_bypass,
  input wire logic [11:0] paddr, input wire logic [31:0] pwdata, input wire logic [3:0] pstrb,
  input wire logic [10:0] np_code, input wire logic [15:0] np_codeword);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic wr = psel && penable && pwrite && paddr[11:2] == 10'h036 && pstrb[0];
  wire logic t = np_codeword[11];
  a_mode_wr: assert property (wr |=> copper_mode == $past(pwdata[6])) else $error("mode");
  a_mode_hold: assert property (!wr |=> $stable(copper_mode)) else $error("mode");
  a_bypass: assert property ({line_coder_bypass, scrambler_bypass} == {2{!copper_mode}})
    else $error("bypass");
  a_first_t: assert property (base_sent |=> t == !$past(base_toggle)) else $error("t0");
  a_flip_t: assert property (page_sent && !base_sent |=> t != $past(t)) else $error("t");
  a_hold_t: assert property (!base_sent && !page_sent |=> $stable(t)) else $error("t");
  a_np_flags: assert property (np_load |=> np_codeword[15:12] ==
    {$past(more_pages_flag), 1'b0, $past(page_type_flag), $past(comply_ack_flag)})
    else $error("flags");
  a_np_code: assert property (np_load |=> np_codeword[10:0] == $past(np_code))
    else $error("code");
  cover property (base_sent && page_sent);
  cover property (wr && !pwdata[6]);
  cover property (np_load ##1 page_sent);
endmodule
bind port_media_next_page_regs pm_mon pm_mon_i (.*);
`default_nettype wire

// >>> verif/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input wire logic clock, pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 0, penable = 0, pwrite = 0,
  output logic [11:0] paddr = 0,
  output logic [31:0] pwdata = 0,
  output logic [3:0] pstrb = 0);
  logic [31:0] rdat;
  logic err;
  // idle edge before setup; on release address and data go inverted, pwrite and pstrb keep their values
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock) {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'hf};
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    {rdat, err} = {prdata, pslverr};
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// >>> verif/port_media_next_page_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module port_media_next_page_regs_tb_top;
  logic clock = 0, rst_n = 0, np_load = 0, base_sent = 0, page_sent = 0, base_toggle = 0;
  logic more_pages_flag = 0, page_type_flag = 0, comply_ack_flag = 0, psel, penable, pwrite;
  logic pready, pslverr, copper_mode, line_coder_bypass, scrambler_bypass;
  logic [10:0] np_code = 0;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, r, s = 69;
  logic [15:0] np_codeword, cfg = 16'h00fe, np = 16'h2001;
  int error_cnt = 0, n_checks = 0;
  always #5 clock = ~clock;
  port_media_next_page_regs port_media_next_page_regs_i (.*);
  apb_host_model apb_host_model_i (.*);
  function logic [31:0] rnd();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction
  function logic [15:0] cfg_next(input logic [31:0] w);
    return (cfg & 16'hff30) | (w[15:0] & 16'h00cf);
  endfunction
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end
  endtask
  task rd(input logic [11:0] a, input logic [15:0] e);
    apb_host_model_i.xfer(1'b0, a, 32'h0);
    chk(apb_host_model_i.rdat, {16'h0, e});
  endtask
  task ev(input logic [2:0] c);
    r = rnd();
    @(posedge clock) {page_sent, base_sent, np_load} <= c;
    {more_pages_flag, page_type_flag, comply_ack_flag, base_toggle, np_code} <= r[14:0];
    if (c[0]) np = {r[14], 1'b0, r[13:12], np[11], r[10:0]};
    if (c[1]) np[11] = !r[11];
    else if (c[2]) np[11] = !np[11];
  endtask
  task results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial #50000 begin error_cnt++; results(); end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1;
    rd(12'h0d8, cfg);
    rd(12'h0dc, np);
    repeat (12) begin
      r = rnd();
      apb_host_model_i.xfer(1'b1, 12'h0d8, r); // dsp clear left to software
      cfg = cfg_next(r);
      rd(12'h0d8, cfg);
      chk({30'h0, line_coder_bypass, scrambler_bypass}, {30'h0, {2{~cfg[6]}}});
      chk({31'h0, copper_mode}, {31'h0, cfg[6]});
    end
    $display("mode done");
    ev(3'b110);
    repeat (40) ev(3'(rnd() >> 29));
    ev(3'b000);
    rd(12'h0dc, np);
    chk({16'h0, np_codeword}, {16'h0, np});
    apb_host_model_i.xfer(1'b0, 12'h100, 32'h0);
    chk({31'h0, apb_host_model_i.err}, 32'h1);
    chk(apb_host_model_i.rdat, 32'h0);
    $display("page done");
    results();
  end
endmodule
`default_nettype wire
